//--- src/boot_image_validator.sv
// Boot image search, validation, copy, remap and handover to the uploader
// Behaviour
// RULE1 - Strap high at reset starts the on-chip boot at address zero.
// RULE2 - Validity is judged only from the first 32 bytes, eight vectors.
// RULE3 - All vectors but the sixth must be branch or load-pc, else invalid.
// RULE4 - A vector needs the unconditional condition code 0xE in bits 31:28.
// RULE5 - Load-pc needs base and destination equal pc, load, pre-index, write-back set.
// RULE6 - A branch needs opcode 1010 in bits 27:24; offset not checked.
// RULE7 - The sixth vector at 0x14 is the descriptor, not an instruction.
// RULE8 - Descriptor bits 7:0 count 512-byte blocks copied, up to 128K.
// RULE9 - Descriptor bits 16:13 give exponent N; page count is two to N.
// RULE10 - Descriptor bits 31:17 give the serial flash page size in bytes.
// RULE11 - Descriptor bits 12:8 are reserved and ignored.
// RULE12 - Two-wire and parallel sources decode only the block count.
// RULE13 - Search serial flash, two-wire EEPROM and 8-bit parallel memory.
// RULE14 - Probe order: SPI chip select zero, two-wire, then bus chip select zero.
// RULE15 - On a valid image copy to SRAM, remap, then start at SRAM start.
// RULE16 - With no valid image start the uploader on debug serial and USB.
// RULE17 - Before remap ROM answers at zero and at 0x0010_0000.
// RULE18 - After remap SRAM decodes at zero, ROM only at its upper base.
// RULE19 - After an uploader download, branch to the SRAM start.
`timescale 1ns/1ps
module boot_image_validator #(
  parameter int MAX_BLOCKS = 256,
  parameter logic [31:0] ROM_SIZE = 32'h0002_0000,
  parameter logic [31:0] SRAM_SIZE = 32'h0000_4000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_boot_source_select,
  // Word read port towards the selected source
  output logic o_rd_req,
  output logic [1:0] o_rd_source,
  output logic [31:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic i_rd_error,
  input wire logic [31:0] i_rd_data,
  // Page addressing for the serial flash
  output logic [14:0] o_flash_page_size,
  output logic [15:0] o_flash_page_count,
  // SRAM write port
  output logic o_sram_we,
  output logic [31:0] o_sram_addr,
  output logic [31:0] o_sram_wdata,
  // Uploader
  output logic o_uploader_start,
  input wire logic i_uploader_done,
  // Map and execution
  input wire logic [31:0] i_map_addr,
  output logic [1:0] o_map_sel,
  output logic [31:0] o_map_offset,
  output logic o_remapped,
  output logic o_cpu_start,
  output logic [31:0] o_cpu_pc,
  output logic o_boot_valid,
  output logic [1:0] o_boot_source
);
  // ********************************************************
  // State
  // ********************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PROBE = 4'h1,
    ST_CHECK = 4'h3,
    ST_COPY = 4'h2,
    ST_REMAP = 4'h6,
    ST_RUN = 4'h7,
    ST_UPLOAD = 4'h5,
    ST_NEXT = 4'h4,
    ST_HALT = 4'hc
  } state_type;

  typedef struct packed {
    state_type state;
    logic strap_meta;
    logic strap_sync;
    // Edges since reset; the strap is judged once its synchroniser is full
    logic [1:0] strap_seen;
    logic up_meta;
    logic up_sync;
    logic [1:0] source;
    logic [2:0] vec_idx;
    logic vec_bad;
    logic [31:0] desc;
    logic [16:0] words_left;
    logic [31:0] addr;
    logic rd_req;
    logic pending;
    logic sram_we;
    logic [31:0] sram_addr;
    logic [31:0] sram_wdata;
    logic [14:0] page_size;
    logic [15:0] page_count;
    logic uploader_start;
    logic remapped;
    logic cpu_start;
    logic [31:0] cpu_pc;
    logic boot_valid;
    logic [1:0] map_sel;
    logic [31:0] map_offset;
  } core_type;

  core_type cur_reg;
  core_type cur_next;
  logic vec_ok;
  logic [7:0] desc_blocks;
  logic [3:0] desc_exp;

  vector_checker u_check (
    .i_word(i_rd_data),
    .o_ok(vec_ok)
  );

  // Fields of the held descriptor; the reserved bits 12:8 are never read
  assign desc_blocks = cur_reg.desc[boot_pkg::BLOCKS_MSB:boot_pkg::BLOCKS_LSB]; // RULE8 RULE11
  assign desc_exp = cur_reg.desc[boot_pkg::PAGES_MSB:boot_pkg::PAGES_LSB]; // RULE9

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    cur_next = cur_reg;
    cur_next.rd_req = 1'b0;
    cur_next.sram_we = 1'b0;
    cur_next.cpu_start = 1'b0;
    // Strap and uploader done come from outside, so both are synchronised
    cur_next.strap_meta = i_boot_source_select;
    cur_next.strap_sync = cur_reg.strap_meta;
    cur_next.up_meta = i_uploader_done;
    cur_next.up_sync = cur_reg.up_meta;
    case (cur_reg.state)
      ST_IDLE: begin
        // Two edges fill the synchroniser, so the strap is judged on the third
        if (cur_reg.strap_seen != 2'h2) begin
          cur_next.strap_seen = cur_reg.strap_seen + 2'h1;
        end else if (cur_reg.strap_sync) begin
          cur_next.cpu_pc = boot_pkg::RESET_VECTOR; // RULE1
          cur_next.source = boot_pkg::SRC_SPI; // RULE14
          cur_next.vec_idx = 3'h0;
          cur_next.vec_bad = 1'b0;
          cur_next.addr = 32'h0000_0000;
          cur_next.state = ST_PROBE;
        end else begin
          cur_next.state = ST_HALT;
        end
      end
      ST_PROBE: begin
        // Fetch one of the eight vectors; only these 32 bytes decide validity
        cur_next.rd_req = 1'b1; // RULE2
        cur_next.state = ST_CHECK;
      end
      ST_CHECK: begin
        // A source that answers with a read error is skipped like one with a bad image
        if (i_rd_error) begin
          cur_next.state = ST_NEXT;
        end else if (i_rd_valid) begin
          if (cur_reg.vec_idx == 3'(boot_pkg::DESC_INDEX)) begin
            cur_next.desc = i_rd_data; // RULE7
          end else if (!vec_ok) begin
            cur_next.vec_bad = 1'b1; // RULE3
          end
          if (cur_reg.vec_idx == 3'(boot_pkg::VECTOR_COUNT - 1)) begin
            if (cur_reg.vec_bad || !vec_ok) begin
              cur_next.state = ST_NEXT;
            end else begin
              // Block count to words: blocks * 512 / 4
              cur_next.words_left = {2'h0, desc_blocks, 7'h00}; // RULE8 RULE11
              // Page fields mean something only for the serial flash
              if (cur_reg.source == boot_pkg::SRC_SPI) begin
                cur_next.page_size = cur_reg.desc[boot_pkg::PSIZE_MSB:boot_pkg::PSIZE_LSB]; // RULE10
                cur_next.page_count = 16'h0001 << desc_exp; // RULE9
              end else begin
                cur_next.page_size = 15'h0000; // RULE12
                cur_next.page_count = 16'h0000; // RULE12
              end
              cur_next.addr = 32'h0000_0000;
              cur_next.sram_addr = boot_pkg::SRAM_START;
              cur_next.boot_valid = 1'b1;
              cur_next.state = ST_COPY; // RULE15
            end
          end else begin
            cur_next.vec_idx = cur_reg.vec_idx + 3'h1;
            cur_next.addr = cur_reg.addr + 32'h0000_0004;
            cur_next.state = ST_PROBE;
          end
        end
      end
      ST_COPY: begin
        // One read in flight at a time: a slow source must never see a second
        // request before it has answered the first
        if (cur_reg.words_left == 17'h00000) begin
          cur_next.state = ST_REMAP;
        end else if (i_rd_error) begin
          cur_next.pending = 1'b0;
          cur_next.boot_valid = 1'b0;
          cur_next.state = ST_NEXT;
        end else if (cur_reg.pending) begin
          if (i_rd_valid) begin
            cur_next.pending = 1'b0;
            cur_next.sram_we = 1'b1; // RULE15
            cur_next.sram_wdata = i_rd_data;
            cur_next.sram_addr = cur_reg.addr;
            cur_next.addr = cur_reg.addr + 32'h0000_0004;
            cur_next.words_left = cur_reg.words_left - 17'h00001;
          end
        end else begin
          cur_next.rd_req = 1'b1;
          cur_next.pending = 1'b1;
        end
      end
      ST_REMAP: begin
        // Remap holds until the next reset; the low window then belongs to SRAM
        cur_next.remapped = 1'b1; // RULE15 RULE18
        cur_next.state = ST_RUN;
      end
      ST_RUN: begin
        // Execution starts at the first SRAM address only once remap is in place
        if (!cur_reg.cpu_start && cur_reg.cpu_pc != 32'hffff_ffff) begin
          cur_next.cpu_start = 1'b1; // RULE15 RULE19
          cur_next.cpu_pc = boot_pkg::SRAM_START;
          cur_next.state = ST_HALT;
        end
      end
      ST_NEXT: begin
        // Drop to the next source in fixed order, or give up to the uploader
        cur_next.vec_idx = 3'h0;
        cur_next.vec_bad = 1'b0;
        cur_next.addr = 32'h0000_0000;
        cur_next.boot_valid = 1'b0;
        if (cur_reg.source == boot_pkg::SRC_PARALLEL) begin
          cur_next.source = boot_pkg::SRC_NONE;
          cur_next.uploader_start = 1'b1; // RULE16
          cur_next.state = ST_UPLOAD;
        end else begin
          cur_next.source = cur_reg.source + 2'h1; // RULE13 RULE14
          cur_next.state = ST_PROBE;
        end
      end
      ST_UPLOAD: begin
        // Uploader owns the debug serial port and USB until it reports done
        if (cur_reg.up_sync) begin
          cur_next.uploader_start = 1'b0;
          cur_next.state = ST_REMAP; // RULE19
        end
      end
      ST_HALT: begin
        // Nothing more to do until the next reset
        cur_next.state = ST_HALT;
      end
      default: begin
        cur_next.state = ST_IDLE;
      end
    endcase
    // Address map: ROM mirrored low until remap, SRAM low afterwards
    // The upper ROM window is tested first and answers whatever the remap state
    cur_next.map_sel = boot_pkg::MAP_NONE;
    cur_next.map_offset = 32'h0000_0000;
    if (i_map_addr >= boot_pkg::ROM_HIGH_BASE
        && i_map_addr < boot_pkg::ROM_HIGH_BASE + ROM_SIZE) begin
      cur_next.map_sel = boot_pkg::MAP_ROM; // RULE17 RULE18
      cur_next.map_offset = i_map_addr - boot_pkg::ROM_HIGH_BASE;
    end else if (!cur_reg.remapped && i_map_addr < ROM_SIZE) begin
      cur_next.map_sel = boot_pkg::MAP_ROM; // RULE17
      cur_next.map_offset = i_map_addr;
    end else if (cur_reg.remapped && i_map_addr < SRAM_SIZE) begin
      cur_next.map_sel = boot_pkg::MAP_SRAM; // RULE18
      cur_next.map_offset = i_map_addr;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Pulses and the map answer start low; the pc starts at the reset vector
      cur_reg <= '0;
      cur_reg.state <= ST_IDLE;
      cur_reg.cpu_pc <= boot_pkg::START_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs straight from the state register
  assign o_rd_req = cur_reg.rd_req;
  assign o_rd_source = cur_reg.source;
  assign o_rd_addr = cur_reg.addr;
  assign o_flash_page_size = cur_reg.page_size;
  assign o_flash_page_count = cur_reg.page_count;
  assign o_sram_we = cur_reg.sram_we;
  assign o_sram_addr = cur_reg.sram_addr;
  assign o_sram_wdata = cur_reg.sram_wdata;
  assign o_uploader_start = cur_reg.uploader_start;
  assign o_map_sel = cur_reg.map_sel;
  assign o_map_offset = cur_reg.map_offset;
  assign o_remapped = cur_reg.remapped;
  assign o_cpu_start = cur_reg.cpu_start;
  assign o_cpu_pc = cur_reg.cpu_pc;
  assign o_boot_valid = cur_reg.boot_valid;
  assign o_boot_source = cur_reg.source;
endmodule

//--- src/boot_pkg.sv
// Package of constants for the boot image validator
package boot_pkg;
  // ********************************************************
  // Image format
  // ********************************************************
  localparam int VECTOR_COUNT = 8;
  localparam int DESC_INDEX = 5;
  localparam logic [31:0] DESC_OFFSET = 32'h0000_0014;
  localparam logic [3:0] COND_ALWAYS = 4'he;
  localparam logic [3:0] OP_BRANCH = 4'ha;
  localparam logic [3:0] PC_CODE = 4'hf;
  localparam int COND_MSB = 31;
  localparam int COND_LSB = 28;
  localparam int OP_MSB = 27;
  localparam int OP_LSB = 24;
  localparam logic [1:0] LDR_TOP = 2'h1;
  localparam int LDR_I_BIT = 25;
  localparam int LDR_P_BIT = 24;
  localparam int LDR_B_BIT = 22;
  localparam int LDR_W_BIT = 21;
  localparam int LDR_L_BIT = 20;
  localparam int BASE_MSB = 19;
  localparam int BASE_LSB = 16;
  localparam int DEST_MSB = 15;
  localparam int DEST_LSB = 12;
  // ********************************************************
  // Descriptor fields
  // ********************************************************
  localparam int BLOCKS_MSB = 7;
  localparam int BLOCKS_LSB = 0;
  localparam int PAGES_MSB = 16;
  localparam int PAGES_LSB = 13;
  localparam int PSIZE_MSB = 31;
  localparam int PSIZE_LSB = 17;
  localparam int BLOCK_BYTES = 512;
  localparam int BLOCK_SHIFT = 9;
  localparam logic [31:0] MAX_IMAGE_BYTES = 32'h0002_0000;
  // ********************************************************
  // Memory map
  // ********************************************************
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [31:0] ROM_HIGH_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_START = 32'h0000_0000;
  // ********************************************************
  // Sources, probed in this order
  // ********************************************************
  localparam logic [1:0] SRC_SPI = 2'h0;
  localparam logic [1:0] SRC_TWO_WIRE = 2'h1;
  localparam logic [1:0] SRC_PARALLEL = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;
  // Map decode answers
  localparam logic [1:0] MAP_NONE = 2'h0;
  localparam logic [1:0] MAP_ROM = 2'h1;
  localparam logic [1:0] MAP_SRAM = 2'h2;
  // Reset value of the program counter handed to the processor
  localparam logic [31:0] START_RESET = 32'h0000_0000;
endpackage

//--- src/vector_checker.sv
// Combinational check of one exception vector word
`timescale 1ns/1ps
module vector_checker (
  input wire logic [31:0] i_word,
  output logic o_ok
);
  logic cond_ok;
  logic branch_ok;
  logic ldr_ok;

  // Unconditional field, then either a branch or a load of the program counter
  always_comb begin
    cond_ok = i_word[boot_pkg::COND_MSB:boot_pkg::COND_LSB] == boot_pkg::COND_ALWAYS; // RULE4
    branch_ok = i_word[boot_pkg::OP_MSB:boot_pkg::OP_LSB] == boot_pkg::OP_BRANCH; // RULE6
    // Offset direction bit is a don't care; byte/word and immediate bits are fixed
    ldr_ok = (i_word[27:26] == boot_pkg::LDR_TOP) && !i_word[boot_pkg::LDR_I_BIT]
      && i_word[boot_pkg::LDR_P_BIT] && !i_word[boot_pkg::LDR_B_BIT]
      && i_word[boot_pkg::LDR_W_BIT] && i_word[boot_pkg::LDR_L_BIT]
      && (i_word[boot_pkg::BASE_MSB:boot_pkg::BASE_LSB] == boot_pkg::PC_CODE)
      && (i_word[boot_pkg::DEST_MSB:boot_pkg::DEST_LSB] == boot_pkg::PC_CODE); // RULE5
    o_ok = cond_ok && (branch_ok || ldr_ok); // RULE3
  end
endmodule

//--- testbench/boot_image_validator_properties.sv
// Port-level checks for the boot image validator
`timescale 1ns/1ps
module boot_image_validator_properties #(
  parameter logic [31:0] ROM_SIZE = 32'h0002_0000,
  parameter logic [31:0] SRAM_SIZE = 32'h0000_4000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  input wire logic [31:0] i_map_addr,
  input wire logic o_rd_req,
  input wire logic [31:0] o_rd_addr,
  input wire logic [1:0] o_rd_source,
  input wire logic [14:0] o_flash_page_size,
  input wire logic [15:0] o_flash_page_count,
  input wire logic o_sram_we,
  input wire logic [31:0] o_sram_wdata,
  input wire logic o_uploader_start,
  input wire logic [1:0] o_map_sel,
  input wire logic [31:0] o_map_offset,
  input wire logic o_remapped,
  input wire logic o_cpu_start,
  input wire logic [31:0] o_cpu_pc,
  input wire logic o_boot_valid,
  input wire logic [1:0] o_boot_source
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Decode steps: address seen, answer a cycle later while the map is unchanged
  sequence s_rom_low;
    !o_remapped && i_map_addr < ROM_SIZE ##1 !o_remapped;
  endsequence
  sequence s_sram_low;
    o_remapped && i_map_addr < SRAM_SIZE ##1 o_remapped;
  endsequence
  AST_ROM_LOW:
    assert property (s_rom_low |-> o_map_sel == boot_pkg::MAP_ROM)
    else $error("rom missing at zero before remap");
  AST_SRAM_LOW:
    assert property (s_sram_low |-> o_map_sel == boot_pkg::MAP_SRAM)
    else $error("sram missing at zero after remap");
  AST_ROM_HIGH:
    assert property (i_map_addr >= boot_pkg::ROM_HIGH_BASE
      && i_map_addr < boot_pkg::ROM_HIGH_BASE + ROM_SIZE |=> o_map_sel == boot_pkg::MAP_ROM
      && o_map_offset == $past(i_map_addr) - boot_pkg::ROM_HIGH_BASE)
    else $error("rom missing at upper base");
  AST_START:
    assert property (o_cpu_start |-> $past(o_remapped) && o_cpu_pc == boot_pkg::SRAM_START)
    else $error("start before remap or bad pc");
  AST_COPY:
    assert property (o_sram_we |-> $past(i_rd_valid) && o_sram_wdata == $past(i_rd_data))
    else $error("sram write without read data");
  AST_ORDER:
    assert property (o_rd_source != $past(o_rd_source)
      |-> o_rd_source == $past(o_rd_source) + 2'h1)
    else $error("source probed out of order");
  AST_PAGES:
    assert property (o_boot_valid && o_boot_source != boot_pkg::SRC_SPI
      |-> o_flash_page_size == 15'h0 && o_flash_page_count == 16'h0)
    else $error("page fields set for non-flash source");
  AST_PROBE_ADDR:
    assert property (o_rd_req && !o_boot_valid |-> o_rd_addr < 32'h0000_0020
      && o_rd_addr[1:0] == 2'h0)
    else $error("probe read outside the vector words");
  AST_UPLOAD:
    assert property (o_uploader_start |-> !o_boot_valid && !o_sram_we)
    else $error("uploader running with a valid image");
endmodule
bind boot_image_validator boot_image_validator_properties #(.ROM_SIZE(ROM_SIZE),
  .SRAM_SIZE(SRAM_SIZE)) u_props (.i_clk, .i_rst, .i_rd_valid, .i_rd_data, .i_map_addr,
  .o_rd_req, .o_rd_addr,
  .o_rd_source, .o_flash_page_size, .o_flash_page_count, .o_sram_we, .o_sram_wdata,
  .o_uploader_start, .o_map_sel, .o_map_offset, .o_remapped, .o_cpu_start, .o_cpu_pc,
  .o_boot_valid, .o_boot_source);

//--- testbench/boot_source_model.sv
// Behavioural model of the three boot sources answering word reads
`timescale 1ns/1ps
module boot_source_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [1:0] i_source,
  input wire logic [31:0] i_addr,
  output logic o_valid,
  output logic o_error,
  output logic [31:0] o_data
);
  // Images and presence flags are filled by the bench
  logic [31:0] mem [3][256];
  bit present [3];
  int lat;
  int cnt;
  bit busy;
  logic [1:0] src_q;
  logic [7:0] idx_q;
  // One answer per request after lat idle cycles; data toggles when not answering
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_error <= 1'b0;
      busy <= 1'b0;
      o_data <= 32'h0;
    end else begin
      o_valid <= 1'b0;
      o_error <= 1'b0;
      o_data <= ~o_data;
      if (i_req) begin
        busy <= 1'b1;
        cnt <= lat;
        src_q <= i_source;
        idx_q <= i_addr[9:2];
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        o_valid <= present[src_q];
        o_error <= !present[src_q];
        if (present[src_q])
          o_data <= mem[src_q][idx_q];
      end
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the boot image validator
`timescale 1ns/1ps
module tb;
  logic i_clk, i_rst, i_boot_source_select, i_uploader_done, i_rd_valid, i_rd_error;
  logic o_rd_req, o_sram_we, o_uploader_start, o_remapped, o_cpu_start, o_boot_valid;
  logic [1:0] o_rd_source, o_map_sel, o_boot_source;
  logic [31:0] i_rd_data, o_rd_addr, o_sram_addr, o_sram_wdata, i_map_addr;
  logic [31:0] o_map_offset, o_cpu_pc, desc;
  logic [14:0] o_flash_page_size;
  logic [15:0] o_flash_page_count;
  logic [31:0] seed = 32'h13932c87;
  int error_cnt = 0;
  int checks_done = 0;
  boot_image_validator u_dut (.i_clk, .i_rst, .i_boot_source_select, .o_rd_req, .o_rd_source,
    .o_rd_addr, .i_rd_valid, .i_rd_error, .i_rd_data, .o_flash_page_size, .o_flash_page_count,
    .o_sram_we, .o_sram_addr, .o_sram_wdata, .o_uploader_start, .i_uploader_done, .i_map_addr,
    .o_map_sel, .o_map_offset, .o_remapped, .o_cpu_start, .o_cpu_pc, .o_boot_valid,
    .o_boot_source);
  boot_source_model u_mem (.i_clk, .i_rst, .i_req(o_rd_req), .i_source(o_rd_source),
    .i_addr(o_rd_addr), .o_valid(i_rd_valid), .o_error(i_rd_error), .o_data(i_rd_data));
  // Clock at 20 MHz
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed;
  endfunction
  // Legal vector: branch or word load into pc with either offset direction
  function automatic logic [31:0] good_vec(input logic [31:0] r);
    if (r[31])
      return {boot_pkg::COND_ALWAYS, boot_pkg::OP_BRANCH, r[23:0]};
    return {boot_pkg::COND_ALWAYS, 4'h5, r[23], 3'h3, 8'hff, r[11:0]};
  endfunction
  // Near misses, each breaking one field of an otherwise legal vector
  function automatic logic [31:0] bad_vec(input int k, input logic [31:0] r);
    case (k)
      0: return {4'hd, boot_pkg::OP_BRANCH, r[23:0]};
      1: return {4'he, 4'hb, r[23:0]};
      2: return {4'he, 4'h5, r[23], 3'h3, 8'hef, r[11:0]};
      3: return {4'he, 4'h5, r[23], 3'h1, 8'hff, r[11:0]};
      4: return {4'he, 4'h5, r[23], 3'h2, 8'hff, r[11:0]};
      default: return {4'he, 4'h4, r[23], 3'h3, 8'hff, r[11:0]};
    endcase
  endfunction
  // Fill a source; the descriptor is random apart from its block count
  task automatic load(input int s, input int blocks, input int bad);
    logic [31:0] r;
    for (int i = 0; i < 256; i++) begin
      r = rnd();
      u_mem.mem[s][i] = (i < 8) ? good_vec(r) : r;
    end
    r = rnd();
    desc = {r[31:8], blocks[7:0]};
    u_mem.mem[s][5] = desc;
    r = rnd();
    if (bad >= 0)
      u_mem.mem[s][r[2:0] == 3'h5 ? 3'h0 : r[2:0]] = bad_vec(bad, rnd());
  endtask
  // Reset, let the search run to the start pulse, then probe the memory map
  task automatic run(input bit strap, input int src, input int blocks);
    logic [31:0] r;
    int k;
    int reqs;
    bit up;
    k = 0;
    reqs = 0;
    up = 1'b0;
    i_boot_source_select = strap;
    i_rst = 1'b1;
    u_mem.lat = rnd() & 32'h3;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    for (int n = 0; n < (strap ? 3000 : 300) && o_cpu_start !== 1'b1; n++) begin
      @(negedge i_clk);
      r = rnd();
      i_map_addr = {11'h0, r[20], 6'h0, r[13:0]};
      if (o_sram_we === 1'b1) begin
        check(o_sram_addr, boot_pkg::SRAM_START + 4 * k, "copy addr");
        check(o_sram_wdata, u_mem.mem[src][k], "copy data");
        k++;
      end
      if (o_rd_req === 1'b1)
        reqs++;
      if (o_uploader_start === 1'b1)
        up = 1'b1;
      i_uploader_done = o_uploader_start;
    end
    check(o_cpu_start, strap, "start");
    check(reqs > 0, strap, "reads");
    if (strap) begin
      check(k, blocks * 128, "words copied");
      check(up, src == 3, "uploader");
    end
    if (strap && src < 3) begin
      check(o_boot_source, src, "source");
      check(o_flash_page_size, src == 0 ? desc[31:17] : 0, "page size");
      check(o_flash_page_count, src == 0 ? 1 << desc[16:13] : 0, "pages");
    end
    i_map_addr = boot_pkg::RESET_VECTOR;
    repeat (2) @(negedge i_clk);
    check(o_map_sel, strap ? boot_pkg::MAP_SRAM : boot_pkg::MAP_ROM, "map zero");
    $display("test done: strap %0d source %0d blocks %0d", strap, src, blocks);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: strap low, good flash, each bad vector kind, fallbacks, uploader
  initial begin
    i_rst = 1'b1;
    i_boot_source_select = 1'b0;
    i_uploader_done = 1'b0;
    i_map_addr = 32'h0;
    u_mem.present = '{1'b1, 1'b1, 1'b1};
    run(1'b0, 3, 0);
    load(0, 1, -1);
    run(1'b1, 0, 1);
    u_mem.present = '{1'b1, 1'b0, 1'b1};
    for (int b = 0; b < 6; b++) begin
      load(0, 1, b);
      load(2, b % 2, -1);
      run(1'b1, 2, b % 2);
    end
    u_mem.present = '{1'b0, 1'b1, 1'b1};
    load(1, 1, -1);
    run(1'b1, 1, 1);
    load(1, 1, 3);
    load(2, 1, 0);
    run(1'b1, 3, 0);
    wrap_up();
  end
  // Watchdog: ten runs of at most about 3100 cycles each, with margin
  initial begin
    #(50 * 60000);
    error_cnt++;
    wrap_up();
  end
endmodule
